// [design/blink_divider.sv]
// divider giving a one-cycle pulse every half lamp period
// assumes the count fits 27 bits
`timescale 1ns/1ps
module blink_divider #(
   parameter int HALF_CYC = 125000000
) (
   input  wire logic CLOCK,
   input  wire logic ARST_N,
   output logic      tick
);
   panel_pkg::blink_state_t q;
   panel_pkg::blink_state_t d;

   always_comb begin
      d = q;
      d.tick = 1'b0;
      if (q.cnt == 27'(HALF_CYC - 1)) begin
         d.cnt  = 27'h0000000;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + 27'h0000001;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule

// [design/front_panel_safety_interlock.sv]
// front panel and pendant safety interlock with apb control and interrupt
// assumes all pins synchronous-ready; switches filtered here before use
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`include "panel_regs.svh"
module front_panel_safety_interlock #(
   parameter int DEBOUNCE_CYCLES   = `DEBOUNCE_CYC,
   parameter int HALF_BLINK_CYCLES = `HALF_BLINK_CYC
) (
   input  wire logic        CLOCK,
   input  wire logic        ARST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic        PRIMARY_STOP,
   input  wire logic        LINE_STOP,
   input  wire logic        GATE_STOP,
   input  wire logic        HOLD_CLOSED,
   input  wire logic        KEY_AUTO,
   input  wire logic        POWER_ON_BTN,
   input  wire logic        LAMP_FAIL,
   input  wire logic [1:0]  FORCED_HALT_LOOP,
   output logic      [1:0]  DUAL_CHANNEL_HALT_N,
   output logic             LINE_HALT_OUT_N,
   output logic             STOP_INDICATOR,
   output logic      [1:0]  MODE_AUTO,
   output logic             HIGH_POWER_LAMP,
   output logic             MOTOR_POWER_EN,
   output logic             IRQ
);
   localparam int NUM_IN = 7;

   panel_pkg::panel_state_t q;
   panel_pkg::panel_state_t d;

   logic [NUM_IN-1:0]     raw_in;
   logic [NUM_IN-1:0]     filt;
   logic                  f_primary;
   logic                  f_line;
   logic                  f_gate;
   logic                  f_hold;
   logic                  f_auto;
   logic                  f_btn;
   logic                  f_fail;
   logic                  force_c;
   logic                  sw_off;
   logic                  blink_on;
   logic                  line_c;
   logic                  other_c;
   logic                  halt_c;
   logic                  btn_rise;
   logic                  tick;
   logic                  wr;
   logic                  rd_setup;
   logic                  hit;
   logic [`STATUS_W-1:0]  status;
   logic [`IRQ_W-1:0]     ev;

   assign raw_in = {LAMP_FAIL, POWER_ON_BTN, KEY_AUTO, HOLD_CLOSED,
                    GATE_STOP, LINE_STOP, PRIMARY_STOP};

   // a debounced stop reacts late by the filter time; bounce would otherwise chatter
   for (genvar i = 0; i < NUM_IN; i++) begin : g_filt
      input_filter #(
         .CNT_MAX (DEBOUNCE_CYCLES)
      ) u_filt (
         .CLOCK  (CLOCK),
         .ARST_N (ARST_N),
         .raw    (raw_in[i]),
         .clean  (filt[i])
      );
   end

   blink_divider #(
      .HALF_CYC (HALF_BLINK_CYCLES)
   ) u_blink (
      .CLOCK  (CLOCK),
      .ARST_N (ARST_N),
      .tick   (tick)
   );

   assign f_primary = filt[0];
   assign f_line    = filt[1];
   assign f_gate    = filt[2];
   assign f_hold    = filt[3];
   assign f_auto    = filt[4];
   assign f_btn     = filt[5];
   assign f_fail    = filt[6];

   assign force_c  = q.ctrl[`CTRL_FORCE];
   assign sw_off   = q.ctrl[`CTRL_PWR_OFF];
   assign blink_on = !q.ctrl[`CTRL_STEADY];

   // line stop kept out of the indicator so a looped-back pair cannot lock up
   assign line_c  = f_line | force_c;
   assign other_c = f_primary | force_c
                  | (f_gate & f_auto)
                  | (!f_hold & !f_auto);
   assign halt_c  = other_c | f_line;

   // the button is momentary; only its low to high step counts
   assign btn_rise = f_btn & !q.btn_prev;

   assign wr       = PSEL & PENABLE & PWRITE;
   assign rd_setup = PSEL & !PENABLE & !PWRITE;
   assign hit      = (PADDR == `OFS_CTRL) | (PADDR == `OFS_STATUS)
                   | (PADDR == `OFS_IRQ_STAT) | (PADDR == `OFS_IRQ_MASK);

   assign status = {f_btn, f_hold, f_gate, f_line, f_primary, f_fail,
                    q.lamp, (q.pwr == panel_pkg::PWR_ON), f_auto,
                    q.stop_ind, !q.line_halt_n, (q.halt_n != 2'h3)};

   always_comb begin
      d  = q;
      ev = '0;

      d.btn_prev  = f_btn;
      d.halt_prev = halt_c;
      d.fail_prev = f_fail;

      // open path reads as stop; closed path copies the forced halt loop
      d.halt_n      = halt_c ? 2'h0 : FORCED_HALT_LOOP;
      d.line_halt_n = !line_c;
      d.stop_ind    = other_c;
      d.mode_auto   = {2{f_auto}};

      unique case (q.pwr)
         panel_pkg::PWR_OFF: begin
            if (btn_rise) begin
               if (halt_c | f_fail | sw_off) begin
                  ev[`IRQ_REFUSED] = 1'b1;
               end else begin
                  d.pwr = panel_pkg::PWR_ON;
                  ev[`IRQ_PWR_ON] = 1'b1;
               end
            end
         end
         panel_pkg::PWR_ON: begin
            if (halt_c | f_fail | sw_off) begin
               d.pwr = panel_pkg::PWR_OFF;
            end
         end
      endcase

      // lamp lags motor power by one cycle in steady mode, lights at the next tick when blinking; steady mode is for lamps that cannot blink
      if (q.pwr == panel_pkg::PWR_ON) begin
         if (blink_on) begin
            d.lamp = tick ? !q.lamp : q.lamp;
         end else begin
            d.lamp = 1'b1;
         end
      end else begin
         d.lamp = 1'b0;
      end

      ev[`IRQ_HALT]      = halt_c & !q.halt_prev;
      ev[`IRQ_LAMP_FAIL] = f_fail & !q.fail_prev;

      if (wr && PADDR == `OFS_CTRL) begin
         d.ctrl = PWDATA[`CTRL_W-1:0];
      end
      if (wr && PADDR == `OFS_IRQ_MASK) begin
         d.irq_mask = PWDATA[`IRQ_W-1:0];
      end

      // a new event in the clearing cycle survives the write
      if (wr && PADDR == `OFS_IRQ_STAT) begin
         d.irq_stat = (q.irq_stat & ~PWDATA[`IRQ_W-1:0]) | ev;
      end else begin
         d.irq_stat = q.irq_stat | ev;
      end
      d.irq = |(d.irq_stat & d.irq_mask);

      if (rd_setup) begin
         unique case (PADDR)
            `OFS_CTRL:     d.prdata = {29'h0, q.ctrl};
            `OFS_STATUS:   d.prdata = {20'h0, status};
            `OFS_IRQ_STAT: d.prdata = {28'h0, q.irq_stat};
            `OFS_IRQ_MASK: d.prdata = {28'h0, q.irq_mask};
            default:       d.prdata = `REG_RESET;
         endcase
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign PRDATA              = q.prdata;
   assign PREADY              = 1'b1;
   assign PSLVERR             = PSEL & PENABLE & !hit;
   assign DUAL_CHANNEL_HALT_N = q.halt_n;
   assign LINE_HALT_OUT_N     = q.line_halt_n;
   assign STOP_INDICATOR      = q.stop_ind;
   assign MODE_AUTO           = q.mode_auto;
   assign HIGH_POWER_LAMP     = q.lamp;
   assign MOTOR_POWER_EN      = (q.pwr == panel_pkg::PWR_ON);
   assign IRQ                 = q.irq;

   property p_halt_open;
      @(posedge CLOCK) disable iff (!ARST_N)
      halt_c |=> (DUAL_CHANNEL_HALT_N == 2'h0);
   endproperty
   a_halt_open: assert property (p_halt_open)
      else $error("halt channels not both open on stop");

   property p_halt_loop;
      @(posedge CLOCK) disable iff (!ARST_N)
      !halt_c |=> (DUAL_CHANNEL_HALT_N == $past(FORCED_HALT_LOOP));
   endproperty
   a_halt_loop: assert property (p_halt_loop)
      else $error("halt channels not following forced halt loop");

   property p_line_halt;
      @(posedge CLOCK) disable iff (!ARST_N)
      ARST_N |=> (LINE_HALT_OUT_N != $past(line_c));
   endproperty
   a_line_halt: assert property (p_line_halt)
      else $error("line halt output wrong");

   property p_indicator;
      @(posedge CLOCK) disable iff (!ARST_N)
      f_line && !other_c |=> !STOP_INDICATOR;
   endproperty
   a_indicator: assert property (p_indicator)
      else $error("stop indicator driven by line stop");

   property p_gate_manual;
      @(posedge CLOCK) disable iff (!ARST_N)
      f_gate && !f_auto && f_hold && !f_primary && !f_line && !force_c
         |=> (DUAL_CHANNEL_HALT_N == $past(FORCED_HALT_LOOP));
   endproperty
   a_gate_manual: assert property (p_gate_manual)
      else $error("gate stop acted in manual mode");

   property p_hold_auto;
      @(posedge CLOCK) disable iff (!ARST_N)
      f_auto && !f_hold && !f_gate && !f_primary && !f_line && !force_c
         |=> (DUAL_CHANNEL_HALT_N == $past(FORCED_HALT_LOOP));
   endproperty
   a_hold_auto: assert property (p_hold_auto)
      else $error("hold circuit acted in automatic mode");

   property p_mode;
      @(posedge CLOCK) disable iff (!ARST_N)
      1'b1 |=> (MODE_AUTO == {2{$past(f_auto)}});
   endproperty
   a_mode: assert property (p_mode)
      else $error("mode outputs disagree with key switch");

   property p_blink;
      @(posedge CLOCK) disable iff (!ARST_N)
      MOTOR_POWER_EN && blink_on && tick
         |=> (HIGH_POWER_LAMP != $past(HIGH_POWER_LAMP));
   endproperty
   a_blink: assert property (p_blink)
      else $error("lamp did not toggle on blink tick");

   property p_lamp_dark;
      @(posedge CLOCK) disable iff (!ARST_N)
      !MOTOR_POWER_EN |=> !HIGH_POWER_LAMP;
   endproperty
   a_lamp_dark: assert property (p_lamp_dark)
      else $error("lamp lit without motor power");

   property p_lamp_fail;
      @(posedge CLOCK) disable iff (!ARST_N)
      f_fail |=> !MOTOR_POWER_EN;
   endproperty
   a_lamp_fail: assert property (p_lamp_fail)
      else $error("motor power on during lamp failure");

   property p_power_edge;
      @(posedge CLOCK) disable iff (!ARST_N)
      !MOTOR_POWER_EN && btn_rise && !halt_c && !f_fail && !sw_off
         |=> MOTOR_POWER_EN;
   endproperty
   a_power_edge: assert property (p_power_edge)
      else $error("power request on rising edge not taken");

   property p_power_level;
      @(posedge CLOCK) disable iff (!ARST_N)
      !MOTOR_POWER_EN && f_btn && $past(f_btn) |=> !MOTOR_POWER_EN;
   endproperty
   a_power_level: assert property (p_power_level)
      else $error("held button enabled power without edge");

   property p_irq_level;
      @(posedge CLOCK) disable iff (!ARST_N)
      ##1 (IRQ == |($past(d.irq_stat) & $past(d.irq_mask)));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt output disagrees with status and mask");

endmodule

// [design/input_filter.sv]
// two-stage synchroniser and debounce for one switch or button
// assumes the switch stays put for CNT_MAX cycles once it settles
`timescale 1ns/1ps
module input_filter #(
   parameter int CNT_MAX = 2500000
) (
   input  wire logic CLOCK,
   input  wire logic ARST_N,
   input  wire logic raw,
   output logic      clean
);
   panel_pkg::filt_state_t q;
   panel_pkg::filt_state_t d;

   always_comb begin
      d = q;
      d.sync1 = raw;
      d.sync2 = q.sync1;
      if (q.sync2 == q.stable) begin
         d.cnt = 24'h000000;
      end else if (q.cnt == 24'(CNT_MAX - 1)) begin
         d.stable = q.sync2;
         d.cnt    = 24'h000000;
      end else begin
         d.cnt = q.cnt + 24'h000001;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign clean = q.stable;
endmodule

// [design/panel_pkg.sv]
// types shared by the front panel interlock and its helpers
// assumes the counts of panel_regs.svh fit the counter widths here
package panel_pkg;

   typedef enum logic {PWR_OFF, PWR_ON} pwr_state_t;

   typedef struct packed {
      logic        sync1;
      logic        sync2;
      logic        stable;
      logic [23:0] cnt;
   } filt_state_t;

   typedef struct packed {
      logic [26:0] cnt;
      logic        tick;
   } blink_state_t;

   typedef struct packed {
      pwr_state_t  pwr;
      logic [2:0]  ctrl;
      logic [3:0]  irq_stat;
      logic [3:0]  irq_mask;
      logic [31:0] prdata;
      logic [1:0]  halt_n;
      logic        line_halt_n;
      logic        stop_ind;
      logic [1:0]  mode_auto;
      logic        lamp;
      logic        irq;
      logic        btn_prev;
      logic        halt_prev;
      logic        fail_prev;
   } panel_state_t;

endpackage

// [design/panel_regs.svh]
// register offsets, field positions, reset values and timing counts
// assumes a 250 MHz CLOCK and apb byte addresses on word boundaries
`ifndef PANEL_REGS_SVH
`define PANEL_REGS_SVH

`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_IRQ_STAT   8'h08
`define OFS_IRQ_MASK   8'h0C

`define CTRL_FORCE     0
`define CTRL_STEADY    1
`define CTRL_PWR_OFF   2
`define CTRL_W         3

`define IRQ_HALT       0
`define IRQ_LAMP_FAIL  1
`define IRQ_PWR_ON     2
`define IRQ_REFUSED    3
`define IRQ_W          4

`define STATUS_W       12
`define REG_RESET      32'h00000000

`define CLK_HZ         250000000
`define DEBOUNCE_MS    10
`define DEBOUNCE_CYC   ((`CLK_HZ / 1000) * `DEBOUNCE_MS)
`define BLINK_HZ       1
`define HALF_BLINK_CYC (`CLK_HZ / (2 * `BLINK_HZ))

`endif

// [tb/panel_partner.sv]
// operator side model: momentary power-on button
// assumes press is a one-cycle request from the bench
`timescale 1ns/1ps
module panel_partner #(
   parameter int PRESS_CYC = 12
) (
   input  wire logic CLOCK,
   input  wire logic press,
   output logic      btn
);
   int n = 0;
   // held long enough to pass the debounce, then released
   always @(posedge CLOCK) begin
      if (press)
         n <= PRESS_CYC;
      else if (n > 0)
         n <= n - 1;
   end
   assign btn = (n > 0);
endmodule

// [tb/tb_front_panel_safety_interlock.sv]
// self-checking bench for the front panel interlock
// assumes short debounce and blink counts for simulation
`timescale 1ns/1ps
module tb_front_panel_safety_interlock;
   localparam int DB = 4;
   logic        CLOCK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic [31:0] seed = 32'h73AA1E0C;
   logic        PREADY, PSLVERR, er, press = 0, lp;
   logic [5:0]  v = 6'h00;
   logic [1:0]  FORCED_HALT_LOOP = 2'h3, DUAL_CHANNEL_HALT_N, MODE_AUTO;
   logic        LINE_HALT_OUT_N, STOP_INDICATOR, HIGH_POWER_LAMP, MOTOR_POWER_EN, IRQ;
   logic        btn;
   int          failures = 0, comparisons = 0, cyc = 0, n, s, x;
   bit          p, l, g, h, k, f;

   front_panel_safety_interlock #(.DEBOUNCE_CYCLES(DB), .HALF_BLINK_CYCLES(8)) dut_u (
      .CLOCK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
      .PREADY, .PSLVERR, .PRIMARY_STOP(v[0]), .LINE_STOP(v[1]), .GATE_STOP(v[2]),
      .HOLD_CLOSED(v[3]), .KEY_AUTO(v[4]), .POWER_ON_BTN(btn), .LAMP_FAIL(v[5]),
      .FORCED_HALT_LOOP, .DUAL_CHANNEL_HALT_N, .LINE_HALT_OUT_N, .STOP_INDICATOR,
      .MODE_AUTO, .HIGH_POWER_LAMP, .MOTOR_POWER_EN, .IRQ
   );
   panel_partner partner_u (.CLOCK(CLOCK), .press(press), .btn(btn));

   always #2 CLOCK = ~CLOCK;

   // ceiling well above the roughly 1400 cycles the run needs
   always @(posedge CLOCK) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         failures++;
         conclude();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic conclude();
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wt(input int c);
      repeat (c) @(posedge CLOCK);
   endtask

   // one apb transfer; an edge between transfers keeps drives single
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLOCK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      @(posedge CLOCK);
      while (PREADY !== 1'b1)
         @(posedge CLOCK);
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic push();
      @(posedge CLOCK);
      press <= 1'b1;
      @(posedge CLOCK);
      press <= 1'b0;
      wt(30);
   endtask

   task automatic setv(input logic [5:0] nv);
      @(posedge CLOCK);
      v <= nv;
      wt(DB + 8);
   endtask

   initial begin
      wt(10);
      ARST_N <= 1'b1;
      apb(0, 8'h10, 32'h0);
      chk(er, 1);
      chk(rd, 32'h0);
      chk(PREADY, 1);
      // every stop combination, with and without the forced stop
      for (int i = 0; i < 64; i++) begin
         x = rnd();
         @(posedge CLOCK);
         FORCED_HALT_LOOP <= x[1:0];
         apb(1, 8'h00, {31'h0, i[5]});
         setv({1'b0, i[4:0]});
         {f, k, h, g, l, p} = i[5:0];
         s = p | f | (g & k) | (!h & !k);
         chk(DUAL_CHANNEL_HALT_N, (s | l) ? 2'h0 : x[1:0]);
         chk(LINE_HALT_OUT_N, !(l | f));
         chk(STOP_INDICATOR, s);
         chk(MODE_AUTO, {k, k});
      end
      apb(1, 8'h00, 32'h0);
      setv(6'h08);
      // a stop shorter than the debounce must not reach the halt outputs
      @(posedge CLOCK);
      v <= 6'h09;
      wt(2);
      v <= 6'h08;
      repeat (12) begin
         @(negedge CLOCK);
         chk(DUAL_CHANNEL_HALT_N, FORCED_HALT_LOOP);
      end
      apb(1, 8'h08, 32'hF);
      apb(1, 8'h0C, 32'hF);
      apb(0, 8'h0C, 32'h0);
      chk(rd, 32'hF);
      push();
      chk(MOTOR_POWER_EN, 1);
      apb(0, 8'h08, 32'h0);
      chk(rd[2], 1);
      // halt bit follows the random loop level and the lamp blinks, so both are masked
      apb(0, 8'h04, 32'h0);
      chk(rd & 32'hFFFFFFDE, 32'h00000410);
      n = 0;
      lp = HIGH_POWER_LAMP;
      repeat (80) begin
         @(negedge CLOCK);
         n += (HIGH_POWER_LAMP !== lp);
         lp = HIGH_POWER_LAMP;
      end
      chk(n >= 9 && n <= 11, 1);
      // manual gate opening keeps power, automatic drops it
      setv(6'h0C);
      chk(MOTOR_POWER_EN, 1);
      setv(6'h1C);
      chk(MOTOR_POWER_EN, 0);
      chk(HIGH_POWER_LAMP, 0);
      setv(6'h28);
      apb(1, 8'h08, 32'hF);
      push();
      chk(MOTOR_POWER_EN, 0);
      apb(0, 8'h08, 32'h0);
      chk(rd[3], 1);
      chk(IRQ, 1);
      apb(1, 8'h08, 32'hF);
      wt(2);
      chk(IRQ, 0);
      setv(6'h08);
      apb(1, 8'h00, 32'h2);
      apb(0, 8'h00, 32'h0);
      chk(rd, 32'h2);
      push();
      chk(MOTOR_POWER_EN, 1);
      chk(HIGH_POWER_LAMP, 1);
      conclude();
   end
endmodule
